// *** hdl/psrl_pkg.sv ***
// Shared constants, carrier types and the frame CRC for the peer status ring link.
// Assumes a single 250 MHz clock domain and an APB master with 32-bit data.
package psrl_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 250_000_000;
	localparam int RATE_FAST_BPS = 128_000;
	localparam int RATE_SLOW_BPS = 64_000;
	localparam logic [11:0] BIT_FAST_CYC = 12'(CLK_HZ / RATE_FAST_BPS);
	localparam logic [11:0] BIT_SLOW_CYC = 12'(CLK_HZ / RATE_SLOW_BPS);
	localparam int INTEGRITY_MS = 1000;
	localparam int INTEGRITY_CYC = (CLK_HZ / 1000) * INTEGRITY_MS;
	localparam int OFFLINE_MS = 3000;
	localparam int OFFLINE_CYC = (CLK_HZ / 1000) * OFFLINE_MS;
	localparam int RING_MS = 2000;
	localparam int RING_CYC = (CLK_HZ / 1000) * RING_MS;

	// ==========================================================
	// Register map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
	localparam logic [1:0] PEER_PAGE = 2'h1;
	localparam int CTRL_RING_BIT = 0;
	localparam int CTRL_FAST_BIT = 1;
	localparam int CTRL_CROSS_BIT = 2;
	localparam int CTRL_ID_LSB = 4;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_00f7;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
	localparam int IRQ_RING_BIT = 0;
	localparam int IRQ_OFF_BIT = 1;
	localparam int IRQ_CRC_BIT = 2;
	localparam int IRQ_RX_BIT = 3;
	localparam int STAT_OFF_LSB = 16;

	// ==========================================================
	// Frame and carriers
	localparam int PEERS = 16;
	localparam int MSG_W = 20;
	localparam int FRAME_W = MSG_W + 32;
	localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
	localparam logic [31:0] CRC_INIT = 32'hffff_ffff;

	typedef struct packed {
		logic [3:0] sender_identifier;
		logic [15:0] status;
	} psrl_msg_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} psrl_apb_req_t;

	function automatic logic [31:0] psrl_crc(input psrl_msg_t m);
		logic [31:0] c;
		logic [MSG_W-1:0] d;
		c = CRC_INIT;
		d = m;
		for (int i = MSG_W - 1; i >= 0; i--) begin
			c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h0000_0000);
		end
		return c;
	endfunction

endpackage

// *** hdl/psrl_chan_tx.sv ***
// One channel transmitter: start bit, message, CRC, stop bit; line idles high.
// Assumes bit_cyc is stable while a frame is on the line.
`timescale 1ns/1ps
module psrl_chan_tx (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [11:0] bit_cyc,
	input psrl_pkg::psrl_msg_t msg,
	input wire logic msg_valid,
	output logic msg_ready,
	output logic tx_line
);
	import psrl_pkg::*;

	typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} psrl_tx_st_t;

	psrl_tx_st_t st_r, st_nxt;
	logic [FRAME_W:0] sh_r, sh_nxt;
	logic [5:0] nbit_r, nbit_nxt;
	logic [11:0] cnt_r, cnt_nxt;
	logic line_nxt;

	assign msg_ready = (st_r == TX_IDLE);

	always_comb begin
		st_nxt = st_r;
		sh_nxt = sh_r;
		nbit_nxt = nbit_r;
		cnt_nxt = cnt_r;
		line_nxt = tx_line;
		unique case (st_r)
			TX_IDLE: begin
				if (msg_valid) begin
					st_nxt = TX_SEND;
					line_nxt = 1'b0;
					sh_nxt = {msg, psrl_crc(msg), 1'b1};
					nbit_nxt = 6'(FRAME_W + 1);
					cnt_nxt = bit_cyc - 12'h001;
				end
			end
			TX_SEND: begin
				if (cnt_r != 12'h000) begin
					cnt_nxt = cnt_r - 12'h001;
				end else if (nbit_r == 6'h00) begin
					st_nxt = TX_IDLE;
				end else begin
					line_nxt = sh_r[FRAME_W];
					sh_nxt = {sh_r[FRAME_W-1:0], 1'b1};
					nbit_nxt = nbit_r - 6'h01;
					cnt_nxt = bit_cyc - 12'h001;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r <= TX_IDLE;
			sh_r <= '0;
			nbit_r <= 6'h00;
			cnt_r <= 12'h000;
			tx_line <= 1'b1;
		end else begin
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			nbit_r <= nbit_nxt;
			cnt_r <= cnt_nxt;
			tx_line <= line_nxt;
		end
	end
endmodule

// *** hdl/psrl_chan_rx.sv ***
// One channel receiver: mid-bit sampling, CRC and stop-bit check.
// Assumes the far end uses the same bit period and framing as psrl_chan_tx.
`timescale 1ns/1ps
module psrl_chan_rx (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [11:0] bit_cyc,
	input wire logic rx_line,
	output psrl_pkg::psrl_msg_t msg,
	output logic msg_valid,
	output logic crc_err
);
	import psrl_pkg::*;

	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11} psrl_rx_st_t;

	psrl_rx_st_t st_r, st_nxt;
	logic [FRAME_W-1:0] sh_r, sh_nxt;
	logic [5:0] nbit_r, nbit_nxt;
	logic [11:0] cnt_r, cnt_nxt;
	logic [FRAME_W:0] full;
	psrl_msg_t msg_nxt;
	logic valid_nxt, err_nxt;

	assign full = {sh_r, rx_line};

	always_comb begin
		st_nxt = st_r;
		sh_nxt = sh_r;
		nbit_nxt = nbit_r;
		cnt_nxt = cnt_r;
		msg_nxt = msg;
		valid_nxt = 1'b0;
		err_nxt = 1'b0;
		unique case (st_r)
			RX_IDLE: begin
				if (!rx_line) begin
					st_nxt = RX_START;
					cnt_nxt = bit_cyc >> 1;
				end
			end
			RX_START: begin
				if (cnt_r != 12'h000) begin
					cnt_nxt = cnt_r - 12'h001;
				end else if (!rx_line) begin
					st_nxt = RX_DATA;
					nbit_nxt = 6'h00;
					cnt_nxt = bit_cyc - 12'h001;
				end else begin
					// Glitch, not a start bit
					st_nxt = RX_IDLE;
				end
			end
			RX_DATA: begin
				if (cnt_r != 12'h000) begin
					cnt_nxt = cnt_r - 12'h001;
				end else if (nbit_r == 6'(FRAME_W)) begin
					// Stop bit sampled: frame complete
					st_nxt = RX_IDLE;
					if (full[0] && full[32:1] == psrl_crc(full[FRAME_W:33])) begin
						msg_nxt = full[FRAME_W:33];
						valid_nxt = 1'b1;
					end else begin
						err_nxt = 1'b1;
					end
				end else begin
					sh_nxt = full[FRAME_W-1:0];
					nbit_nxt = nbit_r + 6'h01;
					cnt_nxt = bit_cyc - 12'h001;
				end
			end
			default: begin
				st_nxt = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r <= RX_IDLE;
			sh_r <= '0;
			nbit_r <= 6'h00;
			cnt_r <= 12'h000;
			msg <= '0;
			msg_valid <= 1'b0;
			crc_err <= 1'b0;
		end else begin
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			nbit_r <= nbit_nxt;
			cnt_r <= cnt_nxt;
			msg <= msg_nxt;
			msg_valid <= valid_nxt;
			crc_err <= err_nxt;
		end
	end
endmodule

// *** hdl/psrl_link.sv ***
// Peer status ring link: APB registers, message scheduling, forwarding and
// ring/peer supervision over two serial channels.
// Assumes one 250 MHz clock, synchronous inputs and a synchronous active-low reset.
`timescale 1ns/1ps

// Operation
// - On a dual-channel card every own message is queued on both channels at once and sent on each when it is free.
// - On a single-channel card own messages go out on the first channel only.
// - A received message whose sender is not this node is forwarded onward.
// - With no status change an integrity message still goes out at least every 1000 ms.
// - Changed status is queued in the same scan strobe, sent as soon as the channel is free.
// - In ring mode own messages must come back, otherwise the ring-break flag rises.
// - Each of 16 peers except this node itself has an offline flag set when its messages stop arriving.
// - Every own message carries the configured sender identifier; identifiers are unique per ring.
// - The 128 kbps rate is selectable only on fibre cards; other cards run at 64 kbps.
// - Both channels of a dual card share one link rate.
// - G.703 and RS422 cards are fixed at 64 kbps whatever the rate setting.
// - With channel_cross_link on a dual card, traffic received on one channel is sent on the other.
// - Incoming messages are checked with a 32-bit CRC and rejected when it fails.
module psrl_link #(
	parameter int INTEGRITY_CYC = psrl_pkg::INTEGRITY_CYC,
	parameter int OFFLINE_CYC = psrl_pkg::OFFLINE_CYC,
	parameter int RING_CYC = psrl_pkg::RING_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input psrl_pkg::psrl_apb_req_t apb_req,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic irq,
	input wire logic card_dual,
	input wire logic card_fiber,
	input wire logic scan_strobe,
	input wire logic [15:0] status_in,
	output logic [1:0] tx_line,
	input wire logic [1:0] rx_line,
	output logic ring_break,
	output logic [15:0] peer_offline
);
	import psrl_pkg::*;

	localparam int IW = $clog2(INTEGRITY_CYC + 1);
	localparam int OW = $clog2(OFFLINE_CYC + 1);
	localparam int RW = $clog2(RING_CYC + 1);

	// ==========================================================
	// Declarations
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [3:0] mask_r, mask_nxt;
	logic [3:0] istat_r, istat_nxt;
	logic pready_nxt, pslverr_nxt, irq_nxt;
	logic [31:0] prdata_nxt;
	logic ring_en, cross_en;
	logic [3:0] own_id;
	logic [11:0] bit_cyc_r, bit_cyc_nxt;
	psrl_msg_t own_msg_r, own_msg_nxt;
	logic [15:0] last_sent_r, last_sent_nxt;
	logic [IW-1:0] integ_r, integ_nxt;
	logic [1:0] own_pend_r, own_pend_nxt;
	logic [1:0] fwd_pend_r, fwd_pend_nxt;
	psrl_msg_t fwd_msg_r [2];
	psrl_msg_t fwd_msg_nxt [2];
	logic send_own;
	logic [1:0] tx_valid, tx_ready, tx_go, ch_on;
	psrl_msg_t tx_msg [2];
	psrl_msg_t rx_msg [2];
	logic [1:0] rx_v, rx_err;
	logic [15:0] peer_stat_r [PEERS];
	logic [15:0] peer_stat_nxt [PEERS];
	logic [OW-1:0] off_cnt_r [PEERS];
	logic [OW-1:0] off_cnt_nxt [PEERS];
	logic [15:0] offline_nxt;
	logic [RW-1:0] ring_cnt_r, ring_cnt_nxt;
	logic ring_break_nxt, ring_seen;
	logic [3:0] ev;

	assign ring_en = ctrl_r[CTRL_RING_BIT];
	assign cross_en = ctrl_r[CTRL_CROSS_BIT] & card_dual;
	assign own_id = ctrl_r[CTRL_ID_LSB +: 4];
	assign ch_on = {card_dual, 1'b1};

	// ==========================================================
	// Channels
	generate
		for (genvar c = 0; c < 2; c++) begin : g_ch
			assign tx_valid[c] = own_pend_r[c] | fwd_pend_r[c];
			assign tx_msg[c] = own_pend_r[c] ? own_msg_r : fwd_msg_r[c];
			assign tx_go[c] = tx_valid[c] & tx_ready[c];
			psrl_chan_tx u_tx (
				.clk(clk),
				.rst_b(rst_b),
				.bit_cyc(bit_cyc_r),
				.msg(tx_msg[c]),
				.msg_valid(tx_valid[c]),
				.msg_ready(tx_ready[c]),
				.tx_line(tx_line[c])
			);
			psrl_chan_rx u_rx (
				.clk(clk),
				.rst_b(rst_b),
				.bit_cyc(bit_cyc_r),
				.rx_line(rx_line[c]),
				.msg(rx_msg[c]),
				.msg_valid(rx_v[c]),
				.crc_err(rx_err[c])
			);
		end
	endgenerate

	// ==========================================================
	// Message scheduling
	always_comb begin
		// Only fibre cards may run fast; all others stay at the slow rate
		bit_cyc_nxt = (ctrl_r[CTRL_FAST_BIT] && card_fiber) ? BIT_FAST_CYC : BIT_SLOW_CYC;
		send_own = (scan_strobe && status_in != last_sent_r)
			|| integ_r == IW'(INTEGRITY_CYC - 1);
		integ_nxt = send_own ? '0 : integ_r + 1'b1;
		last_sent_nxt = send_own ? status_in : last_sent_r;
		own_msg_nxt = own_msg_r;
		if (send_own) begin
			own_msg_nxt.sender_identifier = own_id;
			own_msg_nxt.status = status_in;
		end
		own_pend_nxt = own_pend_r;
		fwd_pend_nxt = fwd_pend_r;
		fwd_msg_nxt = fwd_msg_r;
		for (int c = 0; c < 2; c++) begin
			if (tx_go[c] && own_pend_r[c]) begin
				own_pend_nxt[c] = 1'b0;
			end else if (tx_go[c]) begin
				fwd_pend_nxt[c] = 1'b0;
			end
			// New request wins over the completion clear
			if (send_own && ch_on[c]) begin
				own_pend_nxt[c] = 1'b1;
			end
		end
		for (int c = 0; c < 2; c++) begin
			// Bandwidth limit: an unsent forward slot is overwritten by the newest
			if (rx_v[c] && ch_on[c] && rx_msg[c].sender_identifier != own_id) begin
				if (cross_en) begin
					fwd_pend_nxt[1-c] = 1'b1;
					fwd_msg_nxt[1-c] = rx_msg[c];
				end else begin
					fwd_pend_nxt[c] = 1'b1;
					fwd_msg_nxt[c] = rx_msg[c];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bit_cyc_r <= BIT_SLOW_CYC;
			integ_r <= '0;
			last_sent_r <= 16'h0000;
			own_msg_r <= '0;
			own_pend_r <= 2'h0;
			fwd_pend_r <= 2'h0;
			fwd_msg_r <= '{default: '0};
		end else begin
			bit_cyc_r <= bit_cyc_nxt;
			integ_r <= integ_nxt;
			last_sent_r <= last_sent_nxt;
			own_msg_r <= own_msg_nxt;
			own_pend_r <= own_pend_nxt;
			fwd_pend_r <= fwd_pend_nxt;
			fwd_msg_r <= fwd_msg_nxt;
		end
	end

	// ==========================================================
	// Ring and peer supervision
	always_comb begin
		peer_stat_nxt = peer_stat_r;
		off_cnt_nxt = off_cnt_r;
		offline_nxt = peer_offline;
		ring_seen = 1'b0;
		ev = 4'h0;
		for (int p = 0; p < PEERS; p++) begin
			if (off_cnt_r[p] != OW'(OFFLINE_CYC - 1)) begin
				off_cnt_nxt[p] = off_cnt_r[p] + 1'b1;
			end else begin
				offline_nxt[p] = 1'b1;
			end
		end
		for (int c = 0; c < 2; c++) begin
			if (rx_v[c] && ch_on[c]) begin
				ev[IRQ_RX_BIT] = 1'b1;
				if (rx_msg[c].sender_identifier == own_id) begin
					ring_seen = 1'b1;
				end else begin
					peer_stat_nxt[rx_msg[c].sender_identifier] = rx_msg[c].status;
					off_cnt_nxt[rx_msg[c].sender_identifier] = '0;
					offline_nxt[rx_msg[c].sender_identifier] = 1'b0;
				end
			end
			if (rx_err[c] && ch_on[c]) begin
				ev[IRQ_CRC_BIT] = 1'b1;
			end
		end
		// This node never supervises itself
		off_cnt_nxt[own_id] = '0;
		offline_nxt[own_id] = 1'b0;
		ring_cnt_nxt = ring_cnt_r;
		ring_break_nxt = ring_break;
		if (!ring_en) begin
			ring_cnt_nxt = '0;
			ring_break_nxt = 1'b0;
		end else if (ring_seen) begin
			ring_cnt_nxt = '0;
			ring_break_nxt = 1'b0;
		end else if (ring_cnt_r == RW'(RING_CYC - 1)) begin
			ring_break_nxt = 1'b1;
		end else begin
			ring_cnt_nxt = ring_cnt_r + 1'b1;
		end
		ev[IRQ_RING_BIT] = ring_break_nxt & ~ring_break;
		ev[IRQ_OFF_BIT] = |(offline_nxt & ~peer_offline);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			peer_stat_r <= '{default: 16'h0000};
			off_cnt_r <= '{default: '0};
			peer_offline <= 16'h0000;
			ring_cnt_r <= '0;
			ring_break <= 1'b0;
		end else begin
			peer_stat_r <= peer_stat_nxt;
			off_cnt_r <= off_cnt_nxt;
			peer_offline <= offline_nxt;
			ring_cnt_r <= ring_cnt_nxt;
			ring_break <= ring_break_nxt;
		end
	end

	// ==========================================================
	// APB slave and interrupt
	always_comb begin
		logic acc, commit;
		acc = apb_req.psel & apb_req.penable & ~pready;
		commit = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
		pready_nxt = acc;
		prdata_nxt = 32'h0000_0000;
		pslverr_nxt = 1'b0;
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		istat_nxt = istat_r;
		if (apb_req.paddr[7:6] == PEER_PAGE) begin
			prdata_nxt = {16'h0000, peer_stat_r[apb_req.paddr[5:2]]};
		end else begin
			unique case (apb_req.paddr)
				CTRL_OFS: prdata_nxt = ctrl_r;
				STAT_OFS: prdata_nxt = {peer_offline, 14'h0000, |peer_offline, ring_break};
				IRQ_STAT_OFS: prdata_nxt = {28'h0000000, istat_r};
				IRQ_MASK_OFS: prdata_nxt = {28'h0000000, mask_r};
				default: pslverr_nxt = acc;
			endcase
		end
		if (!acc || apb_req.pwrite) begin
			prdata_nxt = 32'h0000_0000;
		end
		if (commit) begin
			if (apb_req.paddr == CTRL_OFS) begin
				ctrl_nxt = apb_req.pwdata & CTRL_WMASK;
			end
			if (apb_req.paddr == IRQ_MASK_OFS) begin
				mask_nxt = apb_req.pwdata[3:0];
			end
			if (apb_req.paddr == IRQ_STAT_OFS) begin
				istat_nxt = istat_r & ~apb_req.pwdata[3:0];
			end
		end
		// Hardware set wins over a write-one-to-clear in the same cycle
		istat_nxt = istat_nxt | ev;
		irq_nxt = |(istat_nxt & mask_nxt);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_r <= CTRL_RST;
			mask_r <= IRQ_MASK_RST;
			istat_r <= 4'h0;
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
			istat_r <= istat_nxt;
			pready <= pready_nxt;
			prdata <= prdata_nxt;
			pslverr <= pslverr_nxt;
			irq <= irq_nxt;
		end
	end
endmodule

// *** test/psrl_peer_relay.sv ***
// Behavioural peer relay on both serial channels: echoes what it hears back.
// Assumes idle-high lines; a cut channel rests at its idle level.
`timescale 1ns/1ps
module psrl_peer_relay (
	input wire logic clk,
	input wire logic [1:0] tx_in,
	input wire logic [1:0] cut,
	output logic [1:0] rx_out
);
	// ==========================================================
	// Forwarding path
	// Frames pass unaltered, so the originator's sender_identifier is kept
	always_ff @(posedge clk) begin
		for (int c = 0; c < 2; c++) begin
			// Broken link: the line falls back to its idle-high level
			rx_out[c] <= cut[c] ? 1'b1 : tx_in[c];
		end
	end
endmodule

// *** test/psrl_link_checker.sv ***
// Concurrent checks on the top ports of the peer status ring link.
// Assumes it is bound to psrl_link in a single clock domain.
`timescale 1ns/1ps
module psrl_link_checker #(
	parameter int INTEGRITY_CYC = 2000,
	parameter int OFFLINE_CYC = 20000,
	parameter int RING_CYC = 20000
) (
	input wire logic clk,
	input wire logic rst_b,
	input psrl_pkg::psrl_apb_req_t apb_req,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic card_dual,
	input wire logic [1:0] tx_line,
	input wire logic ring_break,
	input wire logic [15:0] peer_offline
);
	import psrl_pkg::*;
	// Worst case: integrity slot waits behind a full slow frame
	localparam int FRAME_MAX = (FRAME_W + 2) * int'(BIT_SLOW_CYC) + 8;
	int up_r, up_nxt, gap_r, gap_nxt;
	logic tx0_r;

	// ==========================================================
	// Helper counters
	always_comb begin
		up_nxt = (up_r < OFFLINE_CYC + RING_CYC) ? up_r + 1 : up_r;
		gap_nxt = (tx0_r && !tx_line[0]) ? 0 : gap_r + 1;
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			up_r <= 0;
			gap_r <= 0;
			tx0_r <= 1'b1;
		end else begin
			up_r <= up_nxt;
			gap_r <= gap_nxt;
			tx0_r <= tx_line[0];
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence access_s;
		apb_req.psel && apb_req.penable && !pready;
	endsequence
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	sequence start_s;
		!tx_line[0] [*8];
	endsequence

	apb_answer_a: assert property (access_s |=> answer_s) else $error("access phase not answered in time");
	answer_cause_a: assert property (pready |-> $past(apb_req.psel) && $past(apb_req.penable))
		else $error("pready without access phase");
	err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error answer");
	reset_state_a: assert property (disable iff (1'b0) !rst_b |=> !pready && !irq && tx_line == 2'b11
		&& !ring_break && peer_offline == 16'h0000) else $error("outputs not at reset level");
	single_chan_a: assert property (!card_dual |-> tx_line[1]) else $error("second channel active");
	integrity_gap_a: assert property (gap_r < INTEGRITY_CYC + FRAME_MAX) else $error("no frame start");
	offline_hold_a: assert property (up_r < OFFLINE_CYC - 2 |-> peer_offline == 16'h0000)
		else $error("peer flagged too early");
	ring_hold_a: assert property (up_r < RING_CYC - 2 |-> !ring_break) else $error("ring break too early");
	start_bit_a: assert property ($fell(tx_line[0]) |-> start_s) else $error("start bit too short");
endmodule
bind psrl_link psrl_link_checker #(.INTEGRITY_CYC(INTEGRITY_CYC), .OFFLINE_CYC(OFFLINE_CYC),
	.RING_CYC(RING_CYC)) chk_i (.clk(clk), .rst_b(rst_b), .apb_req(apb_req), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .irq(irq), .card_dual(card_dual), .tx_line(tx_line),
	.ring_break(ring_break), .peer_offline(peer_offline));

// *** test/tb.sv ***
// Self-checking bench for psrl_link: APB tasks, two own frames, supervision flags.
// Assumes a peer relay whose channels are both cut; the card type changes only under reset.
`timescale 1ns/1ps
module tb;
	import psrl_pkg::*;
	logic clk, rst_b, scan_strobe, pready, pslverr, irq, ring_break;
	logic card_dual, card_fiber;
	logic [31:0] prdata, rd;
	logic [15:0] status_in, peer_offline;
	logic [1:0] tx_line, rx_line, cut;
	logic [19:0] msg;
	psrl_apb_req_t req;
	int errors, checks;

	psrl_link #(.INTEGRITY_CYC(2000), .OFFLINE_CYC(20000), .RING_CYC(20000)) DUT (.clk(clk), .rst_b(rst_b),
		.apb_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq), .card_dual(card_dual),
		.card_fiber(card_fiber), .scan_strobe(scan_strobe), .status_in(status_in), .tx_line(tx_line),
		.rx_line(rx_line), .ring_break(ring_break), .peer_offline(peer_offline));
	psrl_peer_relay peer (.clk(clk), .tx_in(tx_line), .cut(cut), .rx_out(rx_line));

	// ==========================================================
	// Tasks
	task automatic complete_run();
		if (errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err_exp);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		// No timeout here: pready ends the wait, or else the watchdog does
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		chk({31'h0, pslverr}, {31'h0, err_exp});
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err_exp);
		apb(1'b0, a, 32'h0000_0000, err_exp);
		chk(rd, exp);
	endtask

	// ==========================================================
	// Clock, reset, watchdog
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		complete_run();
	end

	// ==========================================================
	// Main sequence
	initial begin
		rst_b = 1'b0;
		req = '0;
		scan_strobe = 1'b0;
		status_in = 16'h0000;
		cut = 2'b11;
		card_dual = 1'b1;
		card_fiber = 1'b1;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		rd_chk(CTRL_OFS, CTRL_RST, 1'b0);
		rd_chk(IRQ_MASK_OFS, 32'h0000_0000, 1'b0);
		rd_chk(8'h10, 32'h0000_0000, 1'b1);
		apb(1'b1, CTRL_OFS, 32'h0000_00a3, 1'b0);
		rd_chk(CTRL_OFS, 32'h0000_00a3, 1'b0);
		apb(1'b1, IRQ_MASK_OFS, 32'h0000_0003, 1'b0);
		@(posedge clk);
		status_in <= 16'h5a3c;
		scan_strobe <= 1'b1;
		@(posedge clk);
		scan_strobe <= 1'b0;
		msg = {4'ha, 16'h5a3c};
		// Frame start comes well before the integrity slot
		while (tx_line[0] !== 1'b0) @(posedge clk);
		repeat (976) @(posedge clk);
		chk({30'h0, tx_line}, 32'h0000_0000);
		for (int i = 19; i >= 0; i--) begin
			repeat (1953) @(posedge clk);
			chk({30'h0, tx_line}, {30'h0, {2{msg[i]}}});
		end
		chk({31'h0, irq}, 32'h0000_0001);
		rd_chk(STAT_OFS, {16'hfbff, 14'h0, 2'b11}, 1'b0);
		apb(1'b1, STAT_OFS, 32'hffff_ffff, 1'b0);
		rd_chk(IRQ_STAT_OFS, 32'h0000_0003, 1'b0);
		apb(1'b1, IRQ_MASK_OFS, 32'h0000_0000, 1'b0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
		apb(1'b1, IRQ_MASK_OFS, 32'h0000_0001, 1'b0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0001);
		apb(1'b1, IRQ_STAT_OFS, 32'h0000_0003, 1'b0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
		rd_chk(IRQ_STAT_OFS, 32'h0000_0000, 1'b0);
		chk({15'h0, ring_break, peer_offline}, {15'h0, 1'b1, 16'hfbff});
		// Second reset: single-channel copper card, fast rate requested but not allowed
		@(posedge clk);
		rst_b <= 1'b0;
		card_dual <= 1'b0;
		card_fiber <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd_chk(CTRL_OFS, CTRL_RST, 1'b0);
		apb(1'b1, CTRL_OFS, 32'h0000_00c2, 1'b0);
		@(posedge clk);
		status_in <= 16'h0001;
		scan_strobe <= 1'b1;
		@(posedge clk);
		scan_strobe <= 1'b0;
		while (tx_line[0] !== 1'b0) @(posedge clk);
		// Late in a slow start bit; a fast line would already show the first data bit
		repeat (2928) @(posedge clk);
		chk({30'h0, tx_line}, 32'h0000_0002);
		repeat (3906) @(posedge clk);
		chk({30'h0, tx_line}, 32'h0000_0003);
		complete_run();
	end
endmodule
